// [rtl/tsd_trigger_settle_delay.sv]
// Trigger settle delay timer: holds off the measurement start after a trigger
`timescale 1ns/1ps
module tsd_trigger_settle_delay
    import tsd_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = TSD_CYC_PER_MS
)(
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire logic     i_ce,
    input  wire logic     i_trig,
    input  wire tsd_sel_s i_sel,
    output logic          o_busy,
    output logic          o_start
);

    // ==================== Parameter check
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) begin : g_bad_cyc_per_ms
        $error("CYC_PER_MS must lie between 1 and 65535");
    end

    // ==================== Decode helpers
    function automatic logic volt_func(input tsd_func_e fn);
        return (fn == TSD_FN_DIRECT_VOLTAGE) || (fn == TSD_FN_ALTERNATING_VOLTAGE)
            || (fn == TSD_FN_DIRECT_PLUS_ALT_VOLTAGE);
    endfunction : volt_func

    function automatic logic volt_step(input logic [2:0] from_rng, input logic [2:0] to_rng);
        return ((from_rng == TSD_RNG_V10) && (to_rng == TSD_RNG_V100))
            || ((from_rng == TSD_RNG_V100) && (to_rng == TSD_RNG_V10));
    endfunction : volt_step

    // ==================== Trigger input synchroniser
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else if (i_ce) begin
            trig_s1 <= i_trig;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end
    logic trig_pulse;
    assign trig_pulse = trig_s2 && !trig_s3;

    // ==================== Interval lookup
    logic [TSD_MS_W-1:0] table_ms;
    tsd_delay_table u_table (
        .i_sel (i_sel),
        .o_ms  (table_ms)
    );

    // ==================== Range change detect
    logic [2:0] last_range;
    logic       range_add;
    logic       is_volt;
    logic       range_step;
    assign is_volt    = volt_func(i_sel.func);
    assign range_step = is_volt && volt_step(last_range, i_sel.range);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_range <= 3'h0;
        end else if (i_ce) begin
            last_range <= i_sel.range;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            range_add <= 1'b0;
        end else if (i_ce) begin
            if (range_step) begin
                range_add <= 1'b1;
            end else if (trig_pulse && !o_busy) begin
                range_add <= 1'b0;
            end
        end
    end

    // ==================== Settle timer
    logic [TSD_MS_W:0] ms_left;
    logic [15:0]       cyc_cnt;
    logic [TSD_MS_W:0] next_ms;
    logic              ms_tick;
    logic              expire;
    assign next_ms = {1'b0, table_ms} + (range_add ? (TSD_MS_W+1)'(TSD_MS_RANGE_CHG) : '0);
    assign ms_tick = o_busy && (cyc_cnt == 16'h0000);
    assign expire  = ms_tick && (ms_left <= (TSD_MS_W+1)'(1));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cyc_cnt <= '0;
        end else if (i_ce) begin
            if (trig_pulse || (ms_tick && !expire)) begin
                cyc_cnt <= 16'(CYC_PER_MS - 1);
            end else if (o_busy && (cyc_cnt != 16'h0000)) begin
                cyc_cnt <= cyc_cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ms_left <= '0;
        end else if (i_ce) begin
            if (trig_pulse) begin
                ms_left <= next_ms;
            end else if (ms_tick && !expire) begin
                ms_left <= ms_left - (TSD_MS_W+1)'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy  <= 1'b0;
            o_start <= 1'b0;
        end else if (i_ce) begin
            if (trig_pulse) begin
                o_busy <= 1'b1;
            end else if (expire) begin
                o_busy <= 1'b0;
            end
            o_start <= expire && !trig_pulse;
        end
    end

    // ==================== Settle length watch for the checks
    logic [TSD_MS_W:0] loaded_ms;
    logic [31:0]       settle_cyc;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            loaded_ms  <= '0;
            settle_cyc <= '0;
        end else if (i_ce) begin
            if (trig_pulse) begin
                loaded_ms  <= next_ms;
                settle_cyc <= '0;
            end else if (o_busy) begin
                settle_cyc <= settle_cyc + 32'h0000_0001;
            end
        end
    end

    // ==================== Checks
    AST_NO_START_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_start && $past(i_ce)) |-> $past(o_busy))
        else $error("start without settle");

    AST_TRIG_BUSY: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && trig_pulse) |=> o_busy && !o_start)
        else $error("trigger did not start timer");

    AST_START_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_start && i_ce) |=> !o_start)
        else $error("start not single cycle");

    AST_FIRST_OUT: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.conv == TSD_CONV_FIRST && i_sel.func == TSD_FN_ALTERNATING_VOLTAGE && !i_sel.filter_in)
        |-> table_ms == TSD_MS_W'(300)) else $error("first option filter out not 300");

    AST_FIRST_IN: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.conv == TSD_CONV_FIRST && i_sel.func == TSD_FN_DIRECT_PLUS_ALT_VOLTAGE && i_sel.filter_in)
        |-> table_ms == TSD_MS_W'(1250)) else $error("first option filter in not 1250");

    AST_SECOND: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.conv == TSD_CONV_SECOND && i_sel.func == TSD_FN_ALTERNATING_CURRENT)
        |-> table_ms == (i_sel.filter_in ? TSD_MS_W'(750) : TSD_MS_W'(225))) else $error("second option wrong");

    AST_SECOND_VOLT: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.conv == TSD_CONV_SECOND && i_sel.func == TSD_FN_ALTERNATING_VOLTAGE)
        |-> table_ms == (i_sel.filter_in ? TSD_MS_W'(750) : TSD_MS_W'(225))) else $error("second option volt wrong");

    AST_DIRECT_VOLTAGE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.func == TSD_FN_DIRECT_VOLTAGE) |-> table_ms == (i_sel.filter_in ? TSD_MS_W'(500) : TSD_MS_W'(5)))
        else $error("direct voltage interval wrong");

    AST_DIRECT_CURRENT_IN: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.func == TSD_FN_DIRECT_CURRENT && i_sel.filter_in) |-> table_ms == TSD_MS_W'(500))
        else $error("direct current filter in interval wrong");

    AST_RES_TOP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sel.func == TSD_FN_RESISTANCE && i_sel.range == TSD_RNG_R10M)
        |-> table_ms == (i_sel.filter_in ? TSD_MS_W'(1250) : TSD_MS_W'(150))) else $error("top resistance wrong");

    AST_RANGE_SET: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && range_step) |=> range_add)
        else $error("range step not remembered");

    AST_RANGE_ADD: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && trig_pulse && range_add) |=> ms_left == {1'b0, $past(table_ms)} + 12'h019)
        else $error("range change not added");

    AST_NO_ADD: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && trig_pulse && !range_add) |=> ms_left == {1'b0, $past(table_ms)})
        else $error("interval differs from table");

    AST_LOAD: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && trig_pulse) |=> ms_left == $past(next_ms))
        else $error("interval not loaded");

    AST_SETTLE_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_start && $past(i_ce)) |-> settle_cyc == 32'(loaded_ms) * 32'(CYC_PER_MS))
        else $error("settle length differs from loaded interval");

    AST_BUSY_FALL: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_busy) |-> o_start)
        else $error("settle ended without launch");

    AST_CYC_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
        o_busy |-> cyc_cnt <= 16'(CYC_PER_MS - 1))
        else $error("cycle counter above one millisecond");

    AST_MS_NONZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        o_busy |-> ms_left != '0)
        else $error("busy with no interval left");

    AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_ce |=> $stable(o_busy) && $stable(o_start) && $stable(ms_left) && $stable(cyc_cnt) && $stable(range_add))
        else $error("state moved while enable low");

endmodule : tsd_trigger_settle_delay

// [rtl/tsd_pkg.sv]
// Package for the trigger settle delay timer
package tsd_pkg;

    // ==================== Clock
    localparam int unsigned TSD_CLK_HZ       = 50_000_000;
    localparam int unsigned TSD_CYC_PER_MS   = TSD_CLK_HZ / 1000;

    // ==================== Measurement functions
    typedef enum logic [2:0] {
        TSD_FN_DIRECT_VOLTAGE,
        TSD_FN_ALTERNATING_VOLTAGE,
        TSD_FN_DIRECT_PLUS_ALT_VOLTAGE,
        TSD_FN_DIRECT_CURRENT,
        TSD_FN_ALTERNATING_CURRENT,
        TSD_FN_DIRECT_PLUS_ALT_CURRENT,
        TSD_FN_RESISTANCE
    } tsd_func_e;

    // ==================== Converter option
    typedef enum logic [1:0] {
        TSD_CONV_NONE,
        TSD_CONV_FIRST,
        TSD_CONV_SECOND
    } tsd_conv_e;

    // ==================== Settings that select the interval
    typedef struct packed {
        tsd_func_e  func;
        logic [2:0] range;
        logic       filter_in;
        tsd_conv_e  conv;
    } tsd_sel_s;

    // Range codes for voltage and current
    localparam logic [2:0] TSD_RNG_V10   = 3'h2;
    localparam logic [2:0] TSD_RNG_V100  = 3'h3;
    localparam logic [2:0] TSD_RNG_I10MA = 3'h2;
    localparam logic [2:0] TSD_RNG_I100MA= 3'h3;
    localparam logic [2:0] TSD_RNG_I1A   = 3'h4;
    // Resistance ranges
    localparam logic [2:0] TSD_RNG_R1M   = 3'h5;
    localparam logic [2:0] TSD_RNG_R10M  = 3'h6;

    // ==================== Interval times in ms
    localparam int unsigned TSD_MS_FIRST_OUT   = 300;
    localparam int unsigned TSD_MS_FIRST_IN    = 1250;
    localparam int unsigned TSD_MS_SECOND_OUT  = 225;
    localparam int unsigned TSD_MS_SECOND_IN   = 750;
    localparam int unsigned TSD_MS_RANGE_CHG   = 25;
    localparam int unsigned TSD_MS_DIRECT_VOLTAGE_OUT      = 5;
    localparam int unsigned TSD_MS_DIRECT_VOLTAGE_IN       = 500;
    localparam int unsigned TSD_MS_DIRECT_CURRENT_LO_OUT   = 5;
    localparam int unsigned TSD_MS_DIRECT_CURRENT_10M_OUT  = 10;
    localparam int unsigned TSD_MS_DIRECT_CURRENT_100M_OUT = 20;
    localparam int unsigned TSD_MS_DIRECT_CURRENT_1A_OUT   = 25;
    localparam int unsigned TSD_MS_DIRECT_CURRENT_IN       = 500;
    localparam int unsigned TSD_MS_RES_LO_OUT  = 5;
    localparam int unsigned TSD_MS_RES_1M_OUT  = 15;
    localparam int unsigned TSD_MS_RES_10M_OUT = 150;
    localparam int unsigned TSD_MS_RES_LO_IN   = 500;
    localparam int unsigned TSD_MS_RES_1M_IN   = 600;
    localparam int unsigned TSD_MS_RES_10M_IN  = 1250;

    localparam int unsigned TSD_MS_W = 11;

endpackage : tsd_pkg

// [rtl/tsd_delay_table.sv]
// Lookup of settling interval in ms from function, range, filter and option
`timescale 1ns/1ps
module tsd_delay_table
    import tsd_pkg::*;
(
    input  wire tsd_sel_s              i_sel,
    output logic [TSD_MS_W-1:0]        o_ms
);

    function automatic logic [TSD_MS_W-1:0] ms(input int unsigned v);
        return TSD_MS_W'(v);
    endfunction : ms

    // ==================== Table
    always_comb begin
        o_ms = ms(TSD_MS_DIRECT_VOLTAGE_OUT);
        case (i_sel.func)
            TSD_FN_ALTERNATING_VOLTAGE, TSD_FN_DIRECT_PLUS_ALT_VOLTAGE,
            TSD_FN_ALTERNATING_CURRENT, TSD_FN_DIRECT_PLUS_ALT_CURRENT: begin
                if (i_sel.conv == TSD_CONV_SECOND) begin
                    o_ms = i_sel.filter_in ? ms(TSD_MS_SECOND_IN) : ms(TSD_MS_SECOND_OUT);
                end else begin
                    o_ms = i_sel.filter_in ? ms(TSD_MS_FIRST_IN) : ms(TSD_MS_FIRST_OUT);
                end
            end
            TSD_FN_DIRECT_CURRENT: begin
                if (i_sel.filter_in) begin
                    o_ms = ms(TSD_MS_DIRECT_CURRENT_IN);
                end else begin
                    case (i_sel.range)
                        TSD_RNG_I10MA:  o_ms = ms(TSD_MS_DIRECT_CURRENT_10M_OUT);
                        TSD_RNG_I100MA: o_ms = ms(TSD_MS_DIRECT_CURRENT_100M_OUT);
                        TSD_RNG_I1A:    o_ms = ms(TSD_MS_DIRECT_CURRENT_1A_OUT);
                        default:        o_ms = ms(TSD_MS_DIRECT_CURRENT_LO_OUT);
                    endcase
                end
            end
            TSD_FN_RESISTANCE: begin
                case (i_sel.range)
                    TSD_RNG_R1M:  o_ms = i_sel.filter_in ? ms(TSD_MS_RES_1M_IN) : ms(TSD_MS_RES_1M_OUT);
                    TSD_RNG_R10M: o_ms = i_sel.filter_in ? ms(TSD_MS_RES_10M_IN) : ms(TSD_MS_RES_10M_OUT);
                    default:      o_ms = i_sel.filter_in ? ms(TSD_MS_RES_LO_IN) : ms(TSD_MS_RES_LO_OUT);
                endcase
            end
            default: begin
                o_ms = i_sel.filter_in ? ms(TSD_MS_DIRECT_VOLTAGE_IN) : ms(TSD_MS_DIRECT_VOLTAGE_OUT);
            end
        endcase
    end

endmodule : tsd_delay_table

// [test/tsd_partner.sv]
// Trigger source and measurement controller model for the settle delay timer
`timescale 1ns/1ps
module tsd_partner (
    input  wire logic i_clk,
    input  wire logic i_busy,
    input  wire logic i_start,
    output logic      o_trig
);
    int busy_cyc;
    int starts;

    initial begin
        o_trig   = 1'b0;
        busy_cyc = 0;
        starts   = 0;
    end

    // ==================== Controller side: count settle cycles and launches
    always @(posedge i_clk) begin
        if (i_busy === 1'b1) busy_cyc <= busy_cyc + 1;
        if (i_start === 1'b1) starts <= starts + 1;
    end

    task clr;
        busy_cyc = 0;
        starts   = 0;
    endtask : clr

    // ==================== Trigger source: pulse held three cycles, idle low
    task fire;
        @(negedge i_clk) o_trig = 1'b1;
        repeat (3) @(negedge i_clk);
        o_trig = 1'b0;
    endtask : fire
endmodule : tsd_partner

// [test/tb_top.sv]
// Self-checking bench for the trigger settle delay timer
`timescale 1ns/1ps
module tb_top
    import tsd_pkg::*;
;
    localparam int unsigned CPM = 4;
    localparam int unsigned RETRIG_CYC = 14 + TSD_MS_DIRECT_VOLTAGE_OUT * CPM;
    localparam int unsigned FREEZE_CYC = 10 + TSD_MS_DIRECT_VOLTAGE_OUT * CPM;
    typedef struct { tsd_sel_s sel; int ms; } tsd_row_s;
    logic     i_clk;
    logic     i_rst;
    logic     i_ce;
    logic     trig;
    tsd_sel_s i_sel;
    logic     o_busy;
    logic     o_start;
    int       errors;
    int       checked;
    tsd_row_s rows [21] = '{
        '{'{TSD_FN_ALTERNATING_VOLTAGE, 3'h0, 1'b0, TSD_CONV_FIRST}, 300},
        '{'{TSD_FN_ALTERNATING_VOLTAGE, 3'h0, 1'b1, TSD_CONV_FIRST}, 1250},
        '{'{TSD_FN_DIRECT_PLUS_ALT_VOLTAGE, 3'h0, 1'b0, TSD_CONV_FIRST}, 300},
        '{'{TSD_FN_DIRECT_PLUS_ALT_VOLTAGE, 3'h0, 1'b1, TSD_CONV_FIRST}, 1250},
        '{'{TSD_FN_ALTERNATING_VOLTAGE, 3'h0, 1'b0, TSD_CONV_SECOND}, 225},
        '{'{TSD_FN_DIRECT_PLUS_ALT_VOLTAGE, 3'h0, 1'b1, TSD_CONV_SECOND}, 750},
        '{'{TSD_FN_ALTERNATING_CURRENT, 3'h0, 1'b0, TSD_CONV_SECOND}, 225},
        '{'{TSD_FN_ALTERNATING_CURRENT, 3'h0, 1'b1, TSD_CONV_SECOND}, 750},
        '{'{TSD_FN_DIRECT_PLUS_ALT_CURRENT, 3'h0, 1'b1, TSD_CONV_SECOND}, 750},
        '{'{TSD_FN_DIRECT_VOLTAGE, 3'h0, 1'b0, TSD_CONV_NONE}, 5},
        '{'{TSD_FN_DIRECT_VOLTAGE, 3'h0, 1'b1, TSD_CONV_NONE}, 500},
        '{'{TSD_FN_DIRECT_CURRENT, 3'h2, 1'b0, TSD_CONV_NONE}, 10},
        '{'{TSD_FN_DIRECT_CURRENT, 3'h3, 1'b0, TSD_CONV_NONE}, 20},
        '{'{TSD_FN_DIRECT_CURRENT, 3'h4, 1'b0, TSD_CONV_NONE}, 25},
        '{'{TSD_FN_DIRECT_CURRENT, 3'h0, 1'b0, TSD_CONV_NONE}, 5},
        '{'{TSD_FN_DIRECT_CURRENT, 3'h4, 1'b1, TSD_CONV_NONE}, 500},
        '{'{TSD_FN_RESISTANCE, 3'h0, 1'b0, TSD_CONV_NONE}, 5},
        '{'{TSD_FN_RESISTANCE, 3'h5, 1'b0, TSD_CONV_NONE}, 15},
        '{'{TSD_FN_RESISTANCE, 3'h6, 1'b0, TSD_CONV_NONE}, 150},
        '{'{TSD_FN_RESISTANCE, 3'h5, 1'b1, TSD_CONV_NONE}, 600},
        '{'{TSD_FN_RESISTANCE, 3'h6, 1'b1, TSD_CONV_NONE}, 1250}};

    tsd_trigger_settle_delay #(.CYC_PER_MS(CPM)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_trig(trig),
        .i_sel(i_sel), .o_busy(o_busy), .o_start(o_start));
    tsd_partner p (.i_clk(i_clk), .i_busy(o_busy), .i_start(o_start), .o_trig(trig));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk

    task report_and_stop;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // ==================== Wait for one launch, bounded
    task wait_start;
        int n;
        for (n = 0; n < 6000 && p.starts == 0; n++) @(negedge i_clk);
        if (p.starts == 0) begin
            chk(1'b0, "no launch before timeout");
            report_and_stop();
        end
        repeat (4) @(negedge i_clk);
    endtask : wait_start

    task run(input tsd_sel_s sel, input int ms, input int extra);
        int exp;
        @(negedge i_clk) i_sel = sel;
        repeat (4) @(negedge i_clk);
        p.clr();
        p.fire();
        wait_start();
        exp = ms * CPM + extra;
        chk(p.busy_cyc >= exp - 3 && p.busy_cyc <= exp + 3, $sformatf("settle %0d want %0d", p.busy_cyc, exp));
        chk(p.starts == 1, "launch count");
    endtask : run

    initial begin
        errors  = 0;
        checked = 0;
        i_rst   = 1'b1;
        i_ce    = 1'b1;
        i_sel   = rows[0].sel;
        repeat (4) @(negedge i_clk);
        chk(o_busy === 1'b0 && o_start === 1'b0, "outputs during reset");
        i_rst = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_busy === 1'b0 && o_start === 1'b0, "idle without trigger");
        foreach (rows[i]) run(rows[i].sel, rows[i].ms, 0);
        // ==================== Range step 10V to 100V adds delay once
        run('{TSD_FN_DIRECT_VOLTAGE, TSD_RNG_V10, 1'b0, TSD_CONV_NONE}, 5, 0);
        run('{TSD_FN_DIRECT_VOLTAGE, TSD_RNG_V100, 1'b0, TSD_CONV_NONE}, 30, 0);
        run('{TSD_FN_DIRECT_VOLTAGE, TSD_RNG_V100, 1'b0, TSD_CONV_NONE}, 5, 0);
        // ==================== Retrigger restarts the interval
        p.clr();
        p.fire();
        repeat (10) @(negedge i_clk);
        chk(o_busy === 1'b1 && p.starts == 0, "busy before expiry");
        p.fire();
        wait_start();
        chk(p.busy_cyc >= RETRIG_CYC - 3 && p.busy_cyc <= RETRIG_CYC + 3, "retrigger length");
        chk(p.starts == 1, "single launch after retrigger");
        // ==================== Enable low freezes the settle timer
        p.clr();
        p.fire();
        repeat (4) @(negedge i_clk);
        i_ce = 1'b0;
        repeat (10) @(negedge i_clk);
        chk(o_busy === 1'b1 && o_start === 1'b0 && p.starts == 0, "frozen while enable low");
        i_ce = 1'b1;
        wait_start();
        chk(p.busy_cyc >= FREEZE_CYC - 3 && p.busy_cyc <= FREEZE_CYC + 3, "enable low stretches settle");
        chk(p.starts == 1, "single launch after freeze");
        // ==================== Reset in mid-settle cancels launch
        p.clr();
        p.fire();
        repeat (8) @(negedge i_clk);
        i_rst = 1'b1;
        @(negedge i_clk);
        chk(o_busy === 1'b0 && o_start === 1'b0, "reset mid-settle");
        i_rst = 1'b0;
        repeat (60) @(negedge i_clk);
        chk(p.starts == 0 && o_busy === 1'b0, "no launch after reset");
        // ==================== Step 100V to 10V after reset adds delay
        run('{TSD_FN_DIRECT_VOLTAGE, TSD_RNG_V10, 1'b0, TSD_CONV_NONE}, 30, 0);
        report_and_stop();
    end
endmodule : tb_top
